// ===== rtl/bser_top.sv
// system error reporting logic of the bridge
module bser_top (
   input  wire logic                I_CLK,
   input  wire logic                I_NRST,
   input  wire logic [7:0]          I_ADDR,
   input  wire logic [31:0]         I_WDATA,
   input  wire logic                I_WR,
   input  wire logic                I_RD,
   output logic      [31:0]         O_RDATA,
   input  wire bser_pkg::bser_evt_t I_EVT,
   input  wire logic                I_SECONDARY_SYSTEM_ERROR_N,
   output logic                     O_PRIMARY_SYSTEM_ERROR_N,
   output logic                     O_PRIMARY_SYSTEM_ERROR_OE_N,
   output logic                     O_SECONDARY_PARITY_ERROR_N,
   output logic                     O_SECONDARY_PARITY_ERROR_OE_N,
   output logic                     O_DISCARD
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [bser_pkg::CTRL_W-1:0]  ctrl_q;
   logic [bser_pkg::DIS_N-1:0]   dis_q;
   logic [bser_pkg::RETRY_W-1:0] limit_q;
   logic [bser_pkg::RETRY_W-1:0] retry_q;
   logic [1:0]                   stat_q;
   logic [bser_pkg::EV_N-1:0]    cause_q;
   logic [bser_pkg::EV_N-1:0]    ev;
   logic [bser_pkg::EV_N-1:0]    ev_en;
   logic                         fire;
   logic                         sserr_seen;
   logic                         limit_hit;
   logic                         par_cand;
   logic                         sperr_d;
   logic                         wr_ctrl;
   logic                         wr_stat;
   logic                         wr_cause;

   assign wr_ctrl  = I_WR && I_ADDR == bser_pkg::ADDR_CTRL;
   assign wr_stat  = I_WR && I_ADDR == bser_pkg::ADDR_STATUS;
   assign wr_cause = I_WR && I_ADDR == bser_pkg::ADDR_CAUSE;

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ctrl_q  <= bser_pkg::CTRL_RST;
         dis_q   <= bser_pkg::DISABLE_RST;
         limit_q <= bser_pkg::RETRY_RST;
      end else if (I_WR) begin
         if (wr_ctrl) begin
            ctrl_q <= I_WDATA[bser_pkg::CTRL_W-1:0];
         end
         if (I_ADDR == bser_pkg::ADDR_DISABLE) begin
            dis_q <= I_WDATA[bser_pkg::DIS_N-1:0];
         end
         if (I_ADDR == bser_pkg::ADDR_RETRY) begin
            limit_q <= I_WDATA[bser_pkg::RETRY_W-1:0];
         end
      end
   end

   // ****************************************************************
   // retry counter for the transaction at the queue head
   // ****************************************************************
   assign limit_hit = I_EVT.valid && I_EVT.target_retry &&
                      (retry_q + 25'h0000001 >= limit_q);

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         retry_q <= '0;
      end else if (I_EVT.valid && (I_EVT.delivered || limit_hit ||
                   I_EVT.target_abort || I_EVT.master_abort)) begin
         retry_q <= '0;
      end else if (I_EVT.valid && I_EVT.target_retry) begin
         retry_q <= retry_q + 25'h0000001;
      end
   end

   // posted and delayed write data dropped at the limit
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_DISCARD <= 1'b0;
      end else begin
         O_DISCARD <= limit_hit &&
                      I_EVT.kind != bser_pkg::BSER_READ;
      end
   end

   // ****************************************************************
   // event detection
   // ****************************************************************
   always_comb begin
      par_cand = 1'b0;
      if (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_PWRITE) begin
         par_cand = I_EVT.perr_target && !I_EVT.perr_init
                    && !I_EVT.perr_self
                    && ctrl_q[bser_pkg::CTRL_P_PERR_EN]
                    && ctrl_q[bser_pkg::CTRL_S_PERR_EN];
      end
   end

   assign sserr_seen = !I_SECONDARY_SYSTEM_ERROR_N;

   always_comb begin
      ev = '0;
      ev[bser_pkg::EV_PAR]   = par_cand;
      if (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_PWRITE) begin
         ev[bser_pkg::EV_TABT] = I_EVT.target_abort;
         ev[bser_pkg::EV_MABT] = I_EVT.master_abort;
         ev[bser_pkg::EV_PWRTY] = limit_hit;
      end
      if (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_DWRITE) begin
         ev[bser_pkg::EV_DWRTY] = limit_hit;
      end
      if (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_READ) begin
         ev[bser_pkg::EV_DRRTY] = limit_hit;
      end
      ev[bser_pkg::EV_DTO]  = I_EVT.valid &&
                              I_EVT.completion_timeout;
      ev[bser_pkg::EV_MTO]  = I_EVT.valid && I_EVT.master_timeout;
      ev[bser_pkg::EV_SFWD] = sserr_seen &&
                              ctrl_q[bser_pkg::CTRL_SERR_FWD];
   end

   // per-event disables on the first DIS_N events, master timeout has its own enable only
   always_comb begin
      ev_en = ev;
      ev_en[bser_pkg::DIS_N-1:0] = ev[bser_pkg::DIS_N-1:0] & ~dis_q;
      ev_en[bser_pkg::EV_MTO] = ev[bser_pkg::EV_MTO] &&
                                ctrl_q[bser_pkg::CTRL_MTO_EN];
   end

   assign fire = (|ev_en) && ctrl_q[bser_pkg::CTRL_SERR_EN];

   // ****************************************************************
   // pins
   // ****************************************************************
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_PRIMARY_SYSTEM_ERROR_N    <= 1'b1;
         O_PRIMARY_SYSTEM_ERROR_OE_N <= 1'b1;
      end else begin
         O_PRIMARY_SYSTEM_ERROR_N    <= !fire;
         O_PRIMARY_SYSTEM_ERROR_OE_N <= !fire;
      end
   end

   assign sperr_d = I_EVT.valid && I_EVT.kind == bser_pkg::BSER_DWRITE &&
                    I_EVT.upstream && I_EVT.perr_target &&
                    ctrl_q[bser_pkg::CTRL_S_PERR_EN];

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_SECONDARY_PARITY_ERROR_N    <= 1'b1;
         O_SECONDARY_PARITY_ERROR_OE_N <= 1'b1;
      end else begin
         O_SECONDARY_PARITY_ERROR_N    <= !sperr_d;
         O_SECONDARY_PARITY_ERROR_OE_N <= !sperr_d;
      end
   end

   // ****************************************************************
   // status and cause, set wins over clear
   // ****************************************************************
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         stat_q <= 2'h0;
      end else begin
         stat_q[bser_pkg::STAT_SIG_SERR] <= fire ||
            (stat_q[bser_pkg::STAT_SIG_SERR] &&
             !(wr_stat && I_WDATA[bser_pkg::STAT_SIG_SERR]));
         stat_q[bser_pkg::STAT_RCV_SERR] <= sserr_seen ||
            (stat_q[bser_pkg::STAT_RCV_SERR] &&
             !(wr_stat && I_WDATA[bser_pkg::STAT_RCV_SERR]));
      end
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cause_q <= '0;
      end else begin
         cause_q <= (fire ? ev_en : '0) |
            (cause_q & ~(wr_cause ? I_WDATA[bser_pkg::EV_N-1:0] : '0));
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_RDATA <= 32'h00000000;
      end else if (I_RD) begin
         case (I_ADDR)
            bser_pkg::ADDR_CTRL:    O_RDATA <= 32'(ctrl_q);
            bser_pkg::ADDR_STATUS:  O_RDATA <= 32'(stat_q);
            bser_pkg::ADDR_CAUSE:   O_RDATA <= 32'(cause_q);
            bser_pkg::ADDR_DISABLE: O_RDATA <= 32'(dis_q);
            bser_pkg::ADDR_RETRY:   O_RDATA <= 32'(limit_q);
            default:                O_RDATA <= 32'h00000000;
         endcase
      end else begin
         O_RDATA <= 32'h00000000;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_serr_enable_gate: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      !O_PRIMARY_SYSTEM_ERROR_N |-> $past(ctrl_q[bser_pkg::CTRL_SERR_EN]))
      else $error("serr without enable");
   a_serr_sets_flag: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      !O_PRIMARY_SYSTEM_ERROR_N |-> stat_q[bser_pkg::STAT_SIG_SERR])
      else $error("signaled flag not set");
   a_sserr_recv_flag: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      !I_SECONDARY_SYSTEM_ERROR_N |=> stat_q[bser_pkg::STAT_RCV_SERR])
      else $error("received flag not set");
   a_sserr_forward: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (!I_SECONDARY_SYSTEM_ERROR_N && ctrl_q[bser_pkg::CTRL_SERR_FWD]
       && ctrl_q[bser_pkg::CTRL_SERR_EN]) |=> !O_PRIMARY_SYSTEM_ERROR_N)
      else $error("secondary serr not forwarded");
   a_par_self_block: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.valid && I_EVT.perr_self) |-> !ev[bser_pkg::EV_PAR])
      else $error("self detected parity raised serr");
   a_par_enables: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      ev[bser_pkg::EV_PAR] |-> (ctrl_q[bser_pkg::CTRL_P_PERR_EN] &&
                                ctrl_q[bser_pkg::CTRL_S_PERR_EN]))
      else $error("parity serr without both enables");
   a_par_nonposted: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.kind != bser_pkg::BSER_PWRITE) |-> !ev[bser_pkg::EV_PAR])
      else $error("parity serr on non posted");
   a_cause_recorded: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      $fell(O_PRIMARY_SYSTEM_ERROR_N) |-> (cause_q != '0))
      else $error("cause not recorded");
   a_mto_gate: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (ev[bser_pkg::EV_MTO] && !ctrl_q[bser_pkg::CTRL_MTO_EN]) |->
      !ev_en[bser_pkg::EV_MTO])
      else $error("master timeout not gated");
   a_oe_tracks: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      O_PRIMARY_SYSTEM_ERROR_N == O_PRIMARY_SYSTEM_ERROR_OE_N)
      else $error("serr enable mismatch");

   // ****************************************************************
   // event and pin assertions
   // ****************************************************************
   a_par_downstream: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_PWRITE &&
       !I_EVT.upstream && I_EVT.perr_target && !I_EVT.perr_init &&
       !I_EVT.perr_self && ctrl_q[bser_pkg::CTRL_P_PERR_EN] &&
       ctrl_q[bser_pkg::CTRL_S_PERR_EN]) |-> ev[bser_pkg::EV_PAR])
      else $error("downstream parity event missed");

   a_par_upstream: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_PWRITE &&
       I_EVT.upstream && I_EVT.perr_target && !I_EVT.perr_init &&
       !I_EVT.perr_self && ctrl_q[bser_pkg::CTRL_P_PERR_EN] &&
       ctrl_q[bser_pkg::CTRL_S_PERR_EN]) |-> ev[bser_pkg::EV_PAR])
      else $error("upstream parity event missed");

   a_par_fires: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (ev[bser_pkg::EV_PAR] && !dis_q[bser_pkg::EV_PAR] &&
       ctrl_q[bser_pkg::CTRL_SERR_EN]) |=> !O_PRIMARY_SYSTEM_ERROR_N)
      else $error("parity event did not drive serr");

   a_serr_no_enable: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      !ctrl_q[bser_pkg::CTRL_SERR_EN] |=> O_PRIMARY_SYSTEM_ERROR_N)
      else $error("serr driven while disabled");

   a_sig_flag_set: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      fire |=> stat_q[bser_pkg::STAT_SIG_SERR])
      else $error("signaled flag missed");

   a_fwd_disabled: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (!ctrl_q[bser_pkg::CTRL_SERR_FWD] && !I_EVT.valid) |=>
      O_PRIMARY_SYSTEM_ERROR_N)
      else $error("secondary serr forwarded while disabled");

   a_rcv_no_input: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_SECONDARY_SYSTEM_ERROR_N && !stat_q[bser_pkg::STAT_RCV_SERR]) |=>
      !stat_q[bser_pkg::STAT_RCV_SERR])
      else $error("received flag set without input");

   a_tabt_fires: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_PWRITE &&
       I_EVT.target_abort) |-> ev[bser_pkg::EV_TABT])
      else $error("target abort event missed");

   a_mabt_fires: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_PWRITE &&
       I_EVT.master_abort) |-> ev[bser_pkg::EV_MABT])
      else $error("master abort event missed");

   a_discard_write: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      O_DISCARD |-> ($past(I_EVT.target_retry) &&
                     $past(I_EVT.kind) != bser_pkg::BSER_READ))
      else $error("discard without write retry");

   a_read_no_discard: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.kind == bser_pkg::BSER_READ) |=> !O_DISCARD)
      else $error("read retry limit discarded data");

   a_retry_restart: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      limit_hit |=> (retry_q == '0))
      else $error("retry count not restarted");

   a_dto_fires: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.valid && I_EVT.completion_timeout) |-> ev[bser_pkg::EV_DTO])
      else $error("completion timeout event missed");

   a_mto_no_disable: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (ev[bser_pkg::EV_MTO] && ctrl_q[bser_pkg::CTRL_MTO_EN]) |->
      ev_en[bser_pkg::EV_MTO])
      else $error("master timeout suppressed by disable");

   a_sperr_drive: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      (I_EVT.valid && I_EVT.kind == bser_pkg::BSER_DWRITE &&
       I_EVT.upstream && I_EVT.perr_target &&
       ctrl_q[bser_pkg::CTRL_S_PERR_EN]) |=> !O_SECONDARY_PARITY_ERROR_N)
      else $error("secondary parity error not driven");

   a_sperr_gate: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      !ctrl_q[bser_pkg::CTRL_S_PERR_EN] |=> O_SECONDARY_PARITY_ERROR_N)
      else $error("secondary parity error without enable");

   a_sperr_oe: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      O_SECONDARY_PARITY_ERROR_N == O_SECONDARY_PARITY_ERROR_OE_N)
      else $error("parity pin enable mismatch");

   a_serr_pulse: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      fire |=> !O_PRIMARY_SYSTEM_ERROR_N)
      else $error("serr pulse missing");

   a_serr_release: assert property (
      @(posedge I_CLK) disable iff (!I_NRST)
      !fire |=> O_PRIMARY_SYSTEM_ERROR_N)
      else $error("serr held without event");

   for (genvar gi = 0; gi < bser_pkg::EV_N; gi++) begin : g_cause
      a_cause_bit: assert property (
         @(posedge I_CLK) disable iff (!I_NRST)
         (fire && ev_en[gi]) |=> cause_q[gi])
         else $error("cause bit not recorded");
      a_cause_quiet: assert property (
         @(posedge I_CLK) disable iff (!I_NRST)
         (!fire && !cause_q[gi]) |=> !cause_q[gi])
         else $error("cause bit set without serr");
   end

   for (genvar gi = 0; gi < bser_pkg::DIS_N; gi++) begin : g_dis
      a_dis_suppress: assert property (
         @(posedge I_CLK) disable iff (!I_NRST)
         dis_q[gi] |-> !ev_en[gi])
         else $error("disabled event not suppressed");
   end
endmodule // bser_top

// ===== pkg/bser_pkg.sv
// package: constants, register map and types of the system error reporter
package bser_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_CAUSE   = 8'h08;
   localparam logic [7:0] ADDR_DISABLE = 8'h0c;
   localparam logic [7:0] ADDR_RETRY   = 8'h10;
   // ctrl fields
   localparam int CTRL_SERR_EN   = 0;
   localparam int CTRL_P_PERR_EN = 1;
   localparam int CTRL_S_PERR_EN = 2;
   localparam int CTRL_SERR_FWD  = 3;
   localparam int CTRL_MTO_EN    = 4;
   localparam int CTRL_W         = 5;
   // status fields, write one to clear
   localparam int STAT_SIG_SERR  = 0;
   localparam int STAT_RCV_SERR  = 1;
   // event numbering, also cause and disable bit positions
   localparam int EV_PAR   = 0;
   localparam int EV_TABT  = 1;
   localparam int EV_MABT  = 2;
   localparam int EV_PWRTY = 3;
   localparam int EV_DWRTY = 4;
   localparam int EV_DRRTY = 5;
   localparam int EV_DTO   = 6;
   localparam int EV_MTO   = 7;
   localparam int EV_SFWD  = 8;
   localparam int EV_N     = 9;
   // events with a device-specific disable bit
   localparam int DIS_N    = 7;
   localparam logic [CTRL_W-1:0] CTRL_RST    = 5'h00;
   localparam logic [DIS_N-1:0]  DISABLE_RST = 7'h00;
   localparam logic [24:0]       RETRY_RST   = 25'h1000000;
   localparam int                RETRY_W     = 25;
   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {BSER_READ, BSER_PWRITE, BSER_DWRITE}
      bser_kind_t;
   // one transaction outcome report from the forwarding engine
   typedef struct packed {
      logic       valid;
      bser_kind_t kind;
      logic       upstream;
      logic       perr_target;   // parity error seen on target bus
      logic       perr_init;     // parity error seen on initiator bus
      logic       perr_self;     // bridge detected it as target
      logic       target_abort;
      logic       master_abort;
      logic       target_retry;  // target retry received
      logic       delivered;     // transfer delivered, retries end
      logic       completion_timeout;
      logic       master_timeout;
   } bser_evt_t;
endpackage : bser_pkg

// ===== testbench/bser_agent.sv
// far-side model: secondary bus agent and pulled-up error wires
module bser_agent (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_req,
   input  wire logic i_pserr_n,
   input  wire logic i_pserr_oe_n,
   input  wire logic i_sperr_n,
   input  wire logic i_sperr_oe_n,
   output logic      o_sserr_n,
   output logic      o_pserr_wire,
   output logic      o_sperr_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // secondary agent raises its system error for one clock on request
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sserr_n <= 1'b1;
      end else begin
         o_sserr_n <= ~i_req;
      end
   end
   // ****************************************************************
   // released wires float high through the pull-ups
   // ****************************************************************
   assign o_pserr_wire = i_pserr_oe_n ? 1'b1 : i_pserr_n;
   assign o_sperr_wire = i_sperr_oe_n ? 1'b1 : i_sperr_n;
endmodule // bser_agent

// ===== testbench/tb_top.sv
// testbench of the system error reporting logic
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic [7:0]          addr = 8'h00;
   logic [31:0]         wdata = 32'h0;
   logic                wr_s = 1'b0;
   logic                rd_s = 1'b0;
   logic [31:0]         rdata;
   bser_pkg::bser_evt_t evt = '0;
   logic                req = 1'b0;
   logic                sserr_n, pserr_n, pserr_oe_n, sperr_n, sperr_oe_n;
   logic                pw, sw, disc;
   int                  err_count = 0;
   int                  tests_run = 0;
   localparam bser_pkg::bser_kind_t RD = bser_pkg::BSER_READ;
   localparam bser_pkg::bser_kind_t PW = bser_pkg::BSER_PWRITE;
   localparam bser_pkg::bser_kind_t DW = bser_pkg::BSER_DWRITE;
   initial forever #4 clk = ~clk;
   bser_top u_bser_top (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
      .I_EVT(evt), .I_SECONDARY_SYSTEM_ERROR_N(sserr_n),
      .O_PRIMARY_SYSTEM_ERROR_N(pserr_n),
      .O_PRIMARY_SYSTEM_ERROR_OE_N(pserr_oe_n),
      .O_SECONDARY_PARITY_ERROR_N(sperr_n),
      .O_SECONDARY_PARITY_ERROR_OE_N(sperr_oe_n), .O_DISCARD(disc));
   bser_agent u_bser_agent (.i_clk(clk), .i_nrst(nrst), .i_req(req),
      .i_pserr_n(pserr_n), .i_pserr_oe_n(pserr_oe_n),
      .i_sperr_n(sperr_n), .i_sperr_oe_n(sperr_oe_n),
      .o_sserr_n(sserr_n), .o_pserr_wire(pw), .o_sperr_wire(sw));
   // ****************************************************************
   // compare, bus and closing tasks
   // ****************************************************************
   task automatic chk32(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
         err_count++;
      end
   endtask
   task automatic chk1(input logic g, input logic x);
      chk32({31'h0, g}, {31'h0, x});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_s  <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk32(rdata, x);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   function automatic bser_pkg::bser_evt_t ev(input bser_pkg::bser_kind_t k,
                                              input logic [9:0] f);
      return {1'b1, k, f};
   endfunction
   // ****************************************************************
   // one event: wire levels, pulse length, status and cause
   // ****************************************************************
   task automatic run(input logic [7:0] c, input logic [6:0] d,
                      input logic s, input bser_pkg::bser_evt_t e,
                      input logic f, input int b, input logic p,
                      input logic x);
      wr(bser_pkg::ADDR_CTRL, {24'h0, c});
      wr(bser_pkg::ADDR_DISABLE, {25'h0, d});
      @(posedge clk);
      if (s) req <= 1'b1;
      else evt <= e;
      @(posedge clk);
      req <= 1'b0;
      evt <= '0;
      if (s) @(posedge clk);
      #1;
      chk1(pw, ~f);
      chk1(sw, ~p);
      chk1(disc, x);
      @(posedge clk);
      #1;
      chk1(pw, 1'b1);
      rd(bser_pkg::ADDR_STATUS, {30'h0, s, f});
      rd(bser_pkg::ADDR_CAUSE, f ? 32'h1 << b : 32'h0);
      wr(bser_pkg::ADDR_STATUS, 32'h3);
      wr(bser_pkg::ADDR_CAUSE, 32'h1ff);
   endtask
   initial begin
      #160000;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(bser_pkg::ADDR_CTRL, 32'h0);
      rd(bser_pkg::ADDR_STATUS, 32'h0);
      rd(bser_pkg::ADDR_CAUSE, 32'h0);
      rd(bser_pkg::ADDR_DISABLE, 32'h0);
      rd(bser_pkg::ADDR_RETRY, 32'h1000000);
      wr(8'h14, 32'hffffffff);
      rd(8'h14, 32'h0);
      wr(bser_pkg::ADDR_RETRY, 32'h2);
      rd(bser_pkg::ADDR_RETRY, 32'h2);
      run(8'h07, 7'h00, 0, ev(PW, 10'h100), 1, 0, 0, 0);
      run(8'h07, 7'h00, 0, ev(PW, 10'h300), 1, 0, 0, 0);
      run(8'h07, 7'h00, 0, ev(PW, 10'h180), 0, 0, 0, 0);
      run(8'h07, 7'h00, 0, ev(PW, 10'h140), 0, 0, 0, 0);
      run(8'h03, 7'h00, 0, ev(PW, 10'h100), 0, 0, 0, 0);
      run(8'h07, 7'h00, 0, ev(RD, 10'h100), 0, 0, 0, 0);
      run(8'h07, 7'h00, 0, ev(DW, 10'h300), 0, 0, 1, 0);
      run(8'h03, 7'h00, 0, ev(DW, 10'h300), 0, 0, 0, 0);
      run(8'h07, 7'h00, 0, ev(DW, 10'h100), 0, 0, 0, 0);
      run(8'h01, 7'h00, 0, ev(PW, 10'h020), 1, 1, 0, 0);
      run(8'h00, 7'h00, 0, ev(PW, 10'h020), 0, 1, 0, 0);
      run(8'h01, 7'h02, 0, ev(PW, 10'h020), 0, 1, 0, 0);
      run(8'h01, 7'h00, 0, ev(PW, 10'h010), 1, 2, 0, 0);
      run(8'h01, 7'h00, 0, ev(DW, 10'h002), 1, 6, 0, 0);
      run(8'h01, 7'h7f, 0, ev(RD, 10'h001), 0, 7, 0, 0);
      run(8'h11, 7'h7f, 0, ev(RD, 10'h001), 1, 7, 0, 0);
      run(8'h01, 7'h00, 0, ev(PW, 10'h008), 0, 3, 0, 0);
      run(8'h01, 7'h00, 0, ev(PW, 10'h008), 1, 3, 0, 1);
      run(8'h01, 7'h00, 0, ev(DW, 10'h008), 0, 4, 0, 0);
      run(8'h01, 7'h00, 0, ev(DW, 10'h008), 1, 4, 0, 1);
      run(8'h01, 7'h00, 0, ev(RD, 10'h008), 0, 5, 0, 0);
      run(8'h01, 7'h00, 0, ev(RD, 10'h008), 1, 5, 0, 0);
      run(8'h09, 7'h00, 1, '0, 1, 8, 0, 0);
      run(8'h00, 7'h00, 1, '0, 0, 8, 0, 0);
      end_of_test();
   end
endmodule // tb_top
